// ---- logic/operation_status.sv ----
// operation status structure with its five sub-words and command port
// assumes condition inputs are synchronous to clk and one command per cycle
module operation_status (
    // clock and reset
    input logic clk,
    input logic rst_b,
    // live conditions from the supply
    input status_pkg::cond_in_type cond_in,
    // command port
    input logic cmd_valid,
    input status_pkg::cmd_type cmd,
    // response
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    // summaries
    output logic oper_summary,
    output logic unregulated
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] sel_onehot(input logic [2:0] sel);
        logic [5:0] hot;
        hot = 6'h00;
        if (sel < 3'h6)
        begin
            hot[sel] = 1'b1;
        end
        return hot;
    endfunction : sel_onehot

    function automatic logic [15:0] impl_mask(input int idx);
        logic [15:0] m;
        m = 16'h0000;
        case (idx)
            0: m = status_pkg::OPER_MASK;
            1: m = status_pkg::LOOP_MASK;
            2: m = status_pkg::OFF_MASK;
            3: m = status_pkg::TRIP_MASK;
            4: m = status_pkg::CTRL_MASK;
            5: m = status_pkg::SHARE_MASK;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction : impl_mask

    // keeps the lowest digital source; analog voltage and current may pair
    function automatic logic [7:0] pick_source(input logic [7:0] raw);
        logic [7:0] digital;
        logic [7:0] lowest;
        digital = raw & ~status_pkg::CTRL_ANALOG;
        lowest = digital & (~digital + 8'h01);
        if (digital != 8'h00)
        begin
            return lowest;
        end
        return raw & status_pkg::CTRL_ANALOG;
    endfunction : pick_source

    // ----------------------------------------------------------------
    // condition assembly
    // ----------------------------------------------------------------
    logic [15:0] cell_cond [status_pkg::NUM_REGS];
    logic [15:0] cell_cq [status_pkg::NUM_REGS];
    logic [15:0] cell_ev [status_pkg::NUM_REGS];
    logic [15:0] cell_en [status_pkg::NUM_REGS];
    logic [15:0] cell_ptr [status_pkg::NUM_REGS];
    logic [15:0] cell_ntr [status_pkg::NUM_REGS];
    logic [5:0] cell_sum;
    logic [5:0] hit;
    logic [15:0] oper_cond;
    logic [15:0] off_cond;

    always_comb
    begin
        oper_cond = 16'h0000;
        oper_cond[status_pkg::OPER_TRIM_BIT] = cond_in.trim_mode_active; // R6
        oper_cond[status_pkg::OPER_TRIG_BIT] = cond_in.waiting_trigger; // R6
        oper_cond[status_pkg::OPER_SEQ_BIT] = cond_in.sequence_running; // R6
        oper_cond[status_pkg::OPER_LOOP_BIT] = cell_sum[status_pkg::SEL_LOOP]; // R7
        oper_cond[status_pkg::OPER_OFF_BIT] = cell_sum[status_pkg::SEL_OFF]; // R7
        oper_cond[status_pkg::OPER_CTRL_BIT] = cell_sum[status_pkg::SEL_CTRL]; // R7
        oper_cond[status_pkg::OPER_SHARE_BIT] = cell_sum[status_pkg::SEL_SHARE]; // R7
        off_cond = 16'h0000;
        // several off causes may stand together
        off_cond[status_pkg::OFF_TRIP_BIT] = cell_sum[status_pkg::SEL_TRIP]; // R10 R11
        off_cond[status_pkg::OFF_LOCK_BIT] = cond_in.external_lockout; // R10
        off_cond[status_pkg::OFF_CMD_BIT] = cond_in.command_off; // R10
    end

    assign cell_cond[status_pkg::SEL_OPER] = oper_cond;
    assign cell_cond[status_pkg::SEL_LOOP] = {13'h0000, cond_in.constant_watt_loop, // R8
        cond_in.constant_amp_loop, cond_in.constant_volt_loop};
    assign cell_cond[status_pkg::SEL_OFF] = off_cond;
    assign cell_cond[status_pkg::SEL_TRIP] = {6'h00, cond_in.trip_causes}; // R11
    // share role is not a control source, so it never feeds this word
    assign cell_cond[status_pkg::SEL_CTRL] = {8'h00, pick_source(cond_in.control_source)}; // R12 R13 R14
    assign cell_cond[status_pkg::SEL_SHARE] = {14'h0000, cond_in.share_follower, // R15
        cond_in.share_leader};

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic do_wr_en;
    logic do_wr_ptr;
    logic do_wr_ntr;
    logic do_rd_ev;
    logic do_clear;

    assign hit = cmd_valid ? sel_onehot(cmd.sel) : 6'h00;
    assign do_wr_en = cmd_valid && (cmd.op == status_pkg::OP_WR_ENABLE);
    assign do_wr_ptr = cmd_valid && (cmd.op == status_pkg::OP_WR_PTR);
    assign do_wr_ntr = cmd_valid && (cmd.op == status_pkg::OP_WR_NTR);
    assign do_rd_ev = cmd_valid && (cmd.op == status_pkg::OP_RD_EVENT);
    // the reset command leaves masks and filters alone, so it only answers
    assign do_clear = cmd_valid && (cmd.op == status_pkg::OP_CLEAR); // R16

    // ----------------------------------------------------------------
    // status words
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < status_pkg::NUM_REGS; gi++)
        begin : g_cell
            status_cell #(
                .IMPL_MASK(impl_mask(gi))
            ) u_cell (
                .clk(clk),
                .rst_b(rst_b),
                .cond(cell_cond[gi]),
                .wr_enable(do_wr_en && hit[gi]), // R1
                .wr_ptr(do_wr_ptr && hit[gi]),
                .wr_ntr(do_wr_ntr && hit[gi]),
                .wr_data(cmd.data),
                .rd_event(do_rd_ev && hit[gi]), // R16
                .clr_status(do_clear), // R2 R5
                .cond_q(cell_cq[gi]),
                .event_q(cell_ev[gi]),
                .enable_q(cell_en[gi]),
                .ptr_q(cell_ptr[gi]),
                .ntr_q(cell_ntr[gi]),
                .summary(cell_sum[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // response and unregulated flag
    // ----------------------------------------------------------------
    status_pkg::top_state_type st;
    status_pkg::top_state_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.rsp_valid = cmd_valid;
        next_st.rsp_data = 16'h0000;
        if (cmd_valid && (cmd.sel < 3'h6))
        begin
            unique case (cmd.op)
                status_pkg::OP_RD_COND: next_st.rsp_data = cell_cq[cmd.sel]; // R16
                status_pkg::OP_RD_EVENT: next_st.rsp_data = cell_ev[cmd.sel];
                status_pkg::OP_RD_ENABLE: next_st.rsp_data = cell_en[cmd.sel];
                status_pkg::OP_RD_PTR: next_st.rsp_data = cell_ptr[cmd.sel];
                status_pkg::OP_RD_NTR: next_st.rsp_data = cell_ntr[cmd.sel];
                default: next_st.rsp_data = 16'h0000;
            endcase
        end
        // fed from the loop summary, the same source as operation bit 8, so both
        // flops change on one edge and the flag never disagrees with bit 8
        next_st.unregulated = ~cell_sum[status_pkg::SEL_LOOP]; // R9 R17
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '{rsp_valid: 1'b0, rsp_data: 16'h0000, unregulated: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rsp_valid = st.rsp_valid;
    assign rsp_data = st.rsp_data;
    assign unregulated = st.unregulated;
    assign oper_summary = cell_sum[status_pkg::SEL_OPER]; // R1

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rsp_timing: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_valid |=> rsp_valid ##1 (rsp_valid == $past(cmd_valid)))
        else $error("response not one cycle after command");
    a_unreg_inverse: assert property (@(posedge clk) disable iff (!rst_b) // R17
        unregulated == !cell_cq[status_pkg::SEL_OPER][status_pkg::OPER_LOOP_BIT])
        else $error("unregulated flag not inverse of loop summary bit");
    a_loop_summary: assert property (@(posedge clk) disable iff (!rst_b) // R7
        cell_cq[status_pkg::SEL_OPER][status_pkg::OPER_LOOP_BIT]
        == $past(cell_sum[status_pkg::SEL_LOOP]))
        else $error("operation bit 8 not loop summary");
    a_trip_summary: assert property (@(posedge clk) disable iff (!rst_b) // R11
        cell_cq[status_pkg::SEL_OFF][status_pkg::OFF_TRIP_BIT]
        == $past(cell_sum[status_pkg::SEL_TRIP]))
        else $error("off bit 0 not trip summary");
    a_source_onehot: assert property (@(posedge clk) disable iff (!rst_b) // R12
        $onehot0(cell_cq[status_pkg::SEL_CTRL][7:2])
        && ((cell_cq[status_pkg::SEL_CTRL][7:2] == 6'h00)
        || (cell_cq[status_pkg::SEL_CTRL][1:0] == 2'h0)))
        else $error("control source word not one-hot");
    a_cond_read_keeps: assert property (@(posedge clk) disable iff (!rst_b) // R16
        (cmd_valid && cmd.op == status_pkg::OP_RD_COND && cmd.sel == status_pkg::SEL_OPER)
        |=> rsp_data == $past(cell_cq[status_pkg::SEL_OPER]))
        else $error("condition read returned wrong data");
    a_enable_write: assert property (@(posedge clk) disable iff (!rst_b) // R1
        (do_wr_en && cmd.sel == status_pkg::SEL_LOOP)
        |=> cell_en[status_pkg::SEL_LOOP] == ($past(cmd.data) & status_pkg::LOOP_MASK))
        else $error("enable write not stored");

    c_event_read: cover property (@(posedge clk) disable iff (!rst_b)
        do_rd_ev && (cell_ev[cmd.sel] != 16'h0000));
    c_clear_status: cover property (@(posedge clk) disable iff (!rst_b)
        do_clear && (cell_ev[status_pkg::SEL_TRIP] != 16'h0000));
    c_oper_summary: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(oper_summary));
    c_regulated: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(unregulated));

endmodule : operation_status

// ---- logic/status_pkg.sv ----
// Functional notes
// [R1] an event bit reaches a summary only while its enable bit is set
// [R2] clear-status and reset commands leave every enable mask unchanged
// [R3] a false-to-true change records an event when its positive filter is set
// [R4] both filters set record every change; both clear record nothing
// [R5] clear-status and reset commands leave both transition filters unchanged
// [R6] operation word is 16 bits: bit 0 trim, bit 5 trigger wait, bit 14 sequence
// [R7] operation bits 8 to 11 summarise loop, off-cause, source and share words
// [R8] loop word bits 0, 1, 2 show voltage, current and power regulation
// [R9] with no loop bit active the unregulated flag is raised; the code raises it only while no enabled loop event is latched
// [R10] off-cause bits 0, 1, 2: protection trip, external lockout, command; may overlap
// [R11] trip word bits 0 to 9 hold protection causes; their summary drives off-cause bit 0
// [R12] control source word is one-hot except analog voltage and current together
// [R13] current sharing never sets a control source bit
// [R14] source bits 3, 5, 7 are locked-out forms of bits 2, 4, 6
// [R15] share word bit 0 is leader, bit 1 is follower
// [R16] reading an event word clears it, clear-status clears all; condition reads do not
// [R17] unregulated flag equals the inverse of operation bit 8
// [R18] unimplemented bits read zero in condition, event and summary paths
// [R19] each summary is the OR of that word's enabled event bits
//
// shared constants and types of the operation status block
// assumes one clock domain and a single-command-per-cycle command port
package status_pkg;

    localparam int REG_W = 16;
    localparam int NUM_REGS = 6;

    // --------------------------------------------------------------
    // register selectors
    // --------------------------------------------------------------
    localparam logic [2:0] SEL_OPER = 3'h0;
    localparam logic [2:0] SEL_LOOP = 3'h1;
    localparam logic [2:0] SEL_OFF = 3'h2;
    localparam logic [2:0] SEL_TRIP = 3'h3;
    localparam logic [2:0] SEL_CTRL = 3'h4;
    localparam logic [2:0] SEL_SHARE = 3'h5;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int OPER_TRIM_BIT = 0;
    localparam int OPER_TRIG_BIT = 5;
    localparam int OPER_LOOP_BIT = 8;
    localparam int OPER_OFF_BIT = 9;
    localparam int OPER_CTRL_BIT = 10;
    localparam int OPER_SHARE_BIT = 11;
    localparam int OPER_SEQ_BIT = 14;
    localparam int OFF_TRIP_BIT = 0;
    localparam int OFF_LOCK_BIT = 1;
    localparam int OFF_CMD_BIT = 2;

    // --------------------------------------------------------------
    // implemented-bit masks and reset values
    // --------------------------------------------------------------
    localparam logic [15:0] OPER_MASK = 16'h4f21;
    localparam logic [15:0] LOOP_MASK = 16'h0007;
    localparam logic [15:0] OFF_MASK = 16'h0007;
    localparam logic [15:0] TRIP_MASK = 16'h03ff;
    localparam logic [15:0] CTRL_MASK = 16'h00ff;
    localparam logic [15:0] SHARE_MASK = 16'h0003;
    localparam logic [7:0] CTRL_ANALOG = 8'h03;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] PTR_RESET = 16'hffff;
    localparam logic [15:0] NTR_RESET = 16'h0000;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_RD_COND = 4'h1,
        OP_RD_EVENT = 4'h2,
        OP_RD_ENABLE = 4'h3,
        OP_RD_PTR = 4'h4,
        OP_RD_NTR = 4'h5,
        OP_WR_ENABLE = 4'h6,
        OP_WR_PTR = 4'h7,
        OP_WR_NTR = 4'h8,
        OP_CLEAR = 4'h9,
        OP_RESET = 4'ha
    } cmd_op_type;

    typedef struct packed {
        cmd_op_type op;
        logic [2:0] sel;
        logic [15:0] data;
    } cmd_type;

    typedef struct packed {
        logic trim_mode_active;
        logic waiting_trigger;
        logic sequence_running;
        logic constant_volt_loop;
        logic constant_amp_loop;
        logic constant_watt_loop;
        logic external_lockout;
        logic command_off;
        logic [9:0] trip_causes;
        logic [7:0] control_source;
        logic share_leader;
        logic share_follower;
    } cond_in_type;

    typedef struct packed {
        logic [15:0] prev;
        logic [15:0] events;
        logic [15:0] enable;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic summary;
    } cell_state_type;

    typedef struct packed {
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic unregulated;
    } top_state_type;

endpackage : status_pkg

// ---- logic/status_cell.sv ----
// one status word: condition, filters, event latch, enable mask, summary
// assumes the owner never strobes two commands into it in one cycle
module status_cell #(
    parameter logic [15:0] IMPL_MASK = 16'hffff
) (
    // clock and reset
    input logic clk,
    input logic rst_b,
    // live condition
    input logic [15:0] cond,
    // command strobes
    input logic wr_enable,
    input logic wr_ptr,
    input logic wr_ntr,
    input logic [15:0] wr_data,
    input logic rd_event,
    input logic clr_status,
    // register view
    output logic [15:0] cond_q,
    output logic [15:0] event_q,
    output logic [15:0] enable_q,
    output logic [15:0] ptr_q,
    output logic [15:0] ntr_q,
    output logic summary
);

    status_pkg::cell_state_type st;
    status_pkg::cell_state_type next_st;
    logic [15:0] cond_m;
    logic [15:0] rise;
    logic [15:0] fall;

    // ----------------------------------------------------------------
    // transition detection and event latch
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        cond_m = cond & IMPL_MASK; // R18
        rise = cond_m & ~st.prev & st.ptr; // R3
        fall = ~cond_m & st.prev & st.ntr; // R4
        next_st.prev = cond_m;
        // new transitions win over a clear in the same cycle
        next_st.events = ((rd_event || clr_status) ? 16'h0000 : st.events) | rise | fall; // R16
        // clr_status touches neither masks nor filters
        if (wr_enable)
        begin
            next_st.enable = wr_data & IMPL_MASK; // R2
        end
        if (wr_ptr)
        begin
            next_st.ptr = wr_data & IMPL_MASK; // R5
        end
        if (wr_ntr)
        begin
            next_st.ntr = wr_data & IMPL_MASK; // R5
        end
        next_st.summary = |(next_st.events & next_st.enable); // R1 R19
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '{prev: 16'h0000, events: 16'h0000, enable: status_pkg::ENABLE_RESET,
                    ptr: status_pkg::PTR_RESET & IMPL_MASK, ntr: status_pkg::NTR_RESET,
                    summary: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cond_q = st.prev;
    assign event_q = st.events;
    assign enable_q = st.enable;
    assign ptr_q = st.ptr;
    assign ntr_q = st.ntr;
    assign summary = st.summary;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rise_recorded: assert property (@(posedge clk) disable iff (!rst_b) // R3
        (rise != 16'h0000) |=> ((event_q & $past(rise)) == $past(rise)))
        else $error("enabled rising edge not recorded");
    a_no_filter: assert property (@(posedge clk) disable iff (!rst_b) // R4
        ((event_q & ~$past(event_q) & ~$past(ptr_q | ntr_q)) == 16'h0000))
        else $error("event recorded with both filters clear");
    a_masks_kept: assert property (@(posedge clk) disable iff (!rst_b) // R5
        (clr_status && !wr_enable && !wr_ptr && !wr_ntr)
        |=> $stable(enable_q) && $stable(ptr_q) && $stable(ntr_q))
        else $error("clear changed masks or filters");
    a_clear_events: assert property (@(posedge clk) disable iff (!rst_b) // R16
        (rd_event || clr_status) |=> ((event_q & ~$past(rise | fall)) == 16'h0000))
        else $error("event word not cleared");
    a_summary_gate: assert property (@(posedge clk) disable iff (!rst_b) // R19
        summary == |(event_q & enable_q))
        else $error("summary disagrees with enabled events");
    a_unused_zero: assert property (@(posedge clk) disable iff (!rst_b) // R18
        ((cond_q | event_q) & ~IMPL_MASK) == 16'h0000)
        else $error("unimplemented bit set");

endmodule : status_cell

// ---- tb/test_operation_status.sv ----
// bench for the operation status block: command reads and writes with expected words
// assumes one clock, inputs driven at the falling edge, checks built into the design
module test_operation_status;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk;
    logic rst_b;
    status_pkg::cond_in_type cond_in;
    logic cmd_valid;
    status_pkg::cmd_type cmd;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic oper_summary;
    logic unregulated;
    int n_fail;
    int comparisons;
    logic [15:0] masks [6];
    logic [7:0] src_in [5];
    logic [7:0] src_exp [5];

    operation_status u_operation_status (
        .clk(clk),
        .rst_b(rst_b),
        .cond_in(cond_in),
        .cmd_valid(cmd_valid),
        .cmd(cmd),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .oper_summary(oper_summary),
        .unregulated(unregulated)
    );

    always #2 clk = ~clk;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk16

    task automatic chk1(input string name, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask : chk1

    // one command; the answer is awaited for a few cycles only
    task automatic rd(input status_pkg::cmd_op_type op, input logic [2:0] sel,
                      input logic [15:0] data, input logic [15:0] exp);
        int i;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{op, sel, data};
        for (i = 0; i < 3; i++)
        begin
            @(negedge clk);
            cmd_valid = 1'b0;
            if (rsp_valid === 1'b1)
                break;
        end
        if (i == 3)
        begin
            n_fail++;
            $display("unexpected response wait: expected %h seen none", exp);
            tally_and_finish();
        end
        chk16($sformatf("rsp op %0d sel %0d", op, sel), exp, rsp_data);
    endtask : rd

    // long enough for the trip to off-cause to operation chain to ripple through
    task automatic settle();
        repeat (12) @(negedge clk);
    endtask : settle

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        cond_in = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        n_fail = 0;
        comparisons = 0;
        masks = '{status_pkg::OPER_MASK, status_pkg::LOOP_MASK, status_pkg::OFF_MASK,
                  status_pkg::TRIP_MASK, status_pkg::CTRL_MASK, status_pkg::SHARE_MASK};
        src_in = '{8'h03, 8'h08, 8'h30, 8'h8b, 8'h02};
        src_exp = '{8'h03, 8'h08, 8'h10, 8'h08, 8'h02};
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        chk1("unregulated", 1'b1, unregulated);
        for (int s = 0; s < 6; s++)
        begin
            rd(status_pkg::OP_RD_ENABLE, 3'(s), 16'h0000, 16'h0000);
            rd(status_pkg::OP_RD_PTR, 3'(s), 16'h0000, masks[s]);
            rd(status_pkg::OP_RD_NTR, 3'(s), 16'h0000, 16'h0000);
        end
        rd(status_pkg::OP_RD_COND, 3'h6, 16'h0000, 16'h0000);
        rd(status_pkg::OP_WR_PTR, status_pkg::SEL_LOOP, 16'hffff, 16'h0000);
        rd(status_pkg::OP_RD_PTR, status_pkg::SEL_LOOP, 16'h0000, 16'h0007);
        // operation word own conditions
        cond_in.trim_mode_active = 1'b1;
        cond_in.waiting_trigger = 1'b1;
        cond_in.sequence_running = 1'b1;
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OPER, 16'h0000, 16'h4021);
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_OPER, 16'h0000, 16'h4021);
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_OPER, 16'h0000, 16'h0000);
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OPER, 16'h0000, 16'h4021);
        cond_in.trim_mode_active = 1'b0;
        cond_in.waiting_trigger = 1'b0;
        cond_in.sequence_running = 1'b0;
        settle();
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_OPER, 16'h0000, 16'h0000);
        // filters on the trip word
        rd(status_pkg::OP_WR_PTR, status_pkg::SEL_TRIP, 16'h0000, 16'h0000);
        cond_in.trip_causes = 10'h200;
        settle();
        cond_in.trip_causes = 10'h000;
        settle();
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_TRIP, 16'h0000, 16'h0000);
        rd(status_pkg::OP_WR_PTR, status_pkg::SEL_TRIP, 16'h03ff, 16'h0000);
        rd(status_pkg::OP_WR_NTR, status_pkg::SEL_TRIP, 16'hffff, 16'h0000);
        cond_in.trip_causes = 10'h200;
        settle();
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_TRIP, 16'h0000, 16'h0200);
        cond_in.trip_causes = 10'h000;
        settle();
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_TRIP, 16'h0000, 16'h0200);
        // shutdown chain up to the operation summary
        cond_in.trip_causes = 10'h200;
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OFF, 16'h0000, 16'h0000);
        rd(status_pkg::OP_WR_ENABLE, status_pkg::SEL_TRIP, 16'h0200, 16'h0000);
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OFF, 16'h0000, 16'h0001);
        cond_in.external_lockout = 1'b1;
        cond_in.command_off = 1'b1;
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OFF, 16'h0000, 16'h0007);
        rd(status_pkg::OP_WR_ENABLE, status_pkg::SEL_OFF, 16'h0007, 16'h0000);
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OPER, 16'h0000, 16'h0200);
        chk1("oper_summary", 1'b0, oper_summary);
        rd(status_pkg::OP_WR_ENABLE, status_pkg::SEL_OPER, 16'h0200, 16'h0000);
        settle();
        chk1("oper_summary", 1'b1, oper_summary);
        // clear and reset commands keep masks and filters, clear drops events
        rd(status_pkg::OP_CLEAR, status_pkg::SEL_OPER, 16'h0000, 16'h0000);
        rd(status_pkg::OP_RESET, status_pkg::SEL_OPER, 16'h0000, 16'h0000);
        settle();
        chk1("oper_summary", 1'b0, oper_summary);
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_OFF, 16'h0000, 16'h0006);
        rd(status_pkg::OP_RD_ENABLE, status_pkg::SEL_OPER, 16'h0000, 16'h0200);
        rd(status_pkg::OP_RD_PTR, status_pkg::SEL_TRIP, 16'h0000, 16'h03ff);
        rd(status_pkg::OP_RD_NTR, status_pkg::SEL_TRIP, 16'h0000, 16'h03ff);
        // regulation loops
        rd(status_pkg::OP_WR_ENABLE, status_pkg::SEL_LOOP, 16'h0007, 16'h0000);
        for (int k = 0; k < 3; k++)
        begin
            cond_in.constant_volt_loop = (k == 0);
            cond_in.constant_amp_loop = (k == 1);
            cond_in.constant_watt_loop = (k == 2);
            settle();
            rd(status_pkg::OP_RD_COND, status_pkg::SEL_LOOP, 16'h0000, 16'h0001 << k);
            chk1("unregulated", 1'b0, unregulated);
        end
        cond_in.constant_watt_loop = 1'b0;
        settle();
        rd(status_pkg::OP_RD_EVENT, status_pkg::SEL_LOOP, 16'h0000, 16'h0007);
        settle();
        chk1("unregulated", 1'b1, unregulated);
        // control sources with sharing active
        cond_in.share_leader = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            cond_in.control_source = src_in[k];
            settle();
            rd(status_pkg::OP_RD_COND, status_pkg::SEL_CTRL, 16'h0000, {8'h00, src_exp[k]});
        end
        cond_in.control_source = 8'h00;
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_CTRL, 16'h0000, 16'h0000);
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_SHARE, 16'h0000, 16'h0001);
        cond_in.share_leader = 1'b0;
        cond_in.share_follower = 1'b1;
        settle();
        rd(status_pkg::OP_RD_COND, status_pkg::SEL_SHARE, 16'h0000, 16'h0002);
        tally_and_finish();
    end

endmodule : test_operation_status
